// >>> inc/spec_cmd_pkg.sv
// Constants for the spectral module command register block.
// Assumes byte-addressed registers reached over the module's serial slave port.
package spec_cmd_pkg;

   // Byte addresses of the register file
   localparam logic [6:0] ADDR_INTERP    = 7'h0D;   // Bit 7: shared-axis interpolation enable
   localparam logic [6:0] ADDR_CONFIG    = 7'h0E;   // Gain source, window, units
   localparam logic [6:0] ADDR_EXT_GAIN  = 7'h0F;
   localparam logic [6:0] ADDR_SCAN_0    = 7'h10;   // Scan duration, low byte first
   localparam logic [6:0] ADDR_SCAN_1    = 7'h11;
   localparam logic [6:0] ADDR_SCAN_2    = 7'h12;
   localparam logic [6:0] ADDR_POINTS_0  = 7'h14;
   localparam logic [6:0] ADDR_POINTS_1  = 7'h15;
   localparam logic [6:0] ADDR_OUTSIZE_0 = 7'h16;
   localparam logic [6:0] ADDR_OUTSIZE_1 = 7'h17;
   localparam logic [6:0] ADDR_LAUNCH    = 7'h18;

   // Field positions inside the interp and config bytes
   localparam int POS_INTERP = 7;
   localparam int POS_GAIN   = 1;
   localparam int POS_WIN    = 3;
   localparam int POS_UNITS  = 6;

   // Values after reset
   localparam logic [1:0]  RST_GAIN_SEL = 2'h0;
   localparam logic [2:0]  RST_APODIZATION_WINDOW_SELECT  = 3'h0;
   localparam logic [23:0] RST_SCAN     = 24'h00_0000;
   localparam logic [12:0] RST_POINTS   = 13'h0000;
   localparam logic [7:0]  RST_EXT_GAIN = 8'h00;

   // Gain source and window codes
   localparam logic [1:0] GAIN_FLASHED  = 2'h0;
   localparam logic [1:0] GAIN_COMPUTED = 2'h1;
   localparam logic [1:0] GAIN_EXTERNAL = 2'h2;
   localparam logic [2:0] WIN_BOXCAR    = 3'h0;
   localparam logic [2:0] WIN_EXTERNAL  = 3'h4;

   // Spectrum point steps and the rounding midpoints between them
   localparam logic [12:0] PTS_65     = 13'h0041;
   localparam logic [12:0] PTS_129    = 13'h0081;
   localparam logic [12:0] PTS_257    = 13'h0101;
   localparam logic [12:0] PTS_513    = 13'h0201;
   localparam logic [12:0] PTS_1024   = 13'h0400;
   localparam logic [12:0] PTS_2048   = 13'h0800;
   localparam logic [12:0] PTS_4096   = 13'h1000;
   localparam logic [12:0] MID_97     = 13'h0061;
   localparam logic [12:0] MID_193    = 13'h00C1;
   localparam logic [12:0] MID_385    = 13'h0181;
   localparam logic [12:0] MID_769    = 13'h0301;
   localparam logic [12:0] MID_1536   = 13'h0600;
   localparam logic [12:0] MID_3072   = 13'h0C00;
   localparam logic [12:0] PTS_NATIVE = 13'h1000;   // Length used when interpolation is off

   // Operation codes
   localparam logic [7:0] OP_CAPTURE      = 8'h01;
   localparam logic [7:0] OP_SELF_FIX     = 8'h02;
   localparam logic [7:0] OP_REF_BG       = 8'h03;
   localparam logic [7:0] OP_REF_FIX      = 8'h04;
   localparam logic [7:0] OP_GAIN_TUNE    = 8'h05;
   localparam logic [7:0] OP_SLEEP        = 8'h06;
   localparam logic [7:0] OP_WIN_WRITE    = 8'h07;
   localparam logic [7:0] OP_SPEC_READ    = 8'h08;
   localparam logic [7:0] OP_STORE_FIRST  = 8'h0B;   // Stores self fix, ref fix, gain, window
   localparam logic [7:0] OP_FACTORY      = 8'h0F;
   localparam logic [7:0] OP_BG_SCAN      = 8'h10;
   localparam logic [7:0] OP_SAMPLE_SCAN  = 8'h11;
   localparam logic [7:0] OP_SAVE_CONTEXT = 8'h12;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_BUSY  = 3'b010,
      ST_SLEEP = 3'b100
   } op_state_t;

endpackage

// >>> hdl/spectral_module_command_regs.sv
// Command and configuration registers of a spectral sensing module, with its serial slave port.
// Assumes a host SPI master (mode 0, MSB first) and routines that report completion on op_done.
`timescale 1ns/1ps

// What this block does
// R01: Fixed-point registers mean raw value over two to the quantization length.
// R02: Gain source 0 flashed, 1 last computed, 2 external gain value.
// R03: Window select 0 boxcar, 1 Gaussian, 2 Happ-Genzel, 3 Lorenz, 4 external.
// R04: Units flag 0 reflectance, 1 absorbance, effective only during sample scan.
// R05: Scan duration register holds scan time in milliseconds.
// R06: Point count rounds to nearest of 65,129,257,513,1024,2048,4096.
// R07: Point count applies only while interpolation enable is 1.
// R08: Read-only output size reports produced spectrum length in samples.
// R09: Writing the launch register starts the routine with that code.
// R10: Code 1 starts a density capture.
// R11: Code 2 runs self correction, results kept volatile.
// R12: Code 3 takes reference background; code 4 only after code 3.
// R13: Code 5 runs gain tuning into the computed gain result.
// R14: Code 6 enters sleep; a rising edge on the wake input leaves it.
// R15: Code 7 accepts coefficient write, code 8 accepts spectrum read request.
// R16: Codes 11-13 store corrections and gain, 14 stores window profile.
// R17: Code 15 restores factory corrections and erases user values.
// R18: Code 16 background scan; code 17 sample scan only after 16.
// R19: Code 18 saves context data to flash.
// R20: Undefined codes such as 9 and 10 start nothing.
// R21: Host opens a write frame only while the ready flag reads 1; the host model opens one anyway after 500 cycles.
module spectral_module_command_regs
   import spec_cmd_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        spi_csb,
   input  wire logic        spi_clk,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   input  wire logic        wake_input,
   output logic             command_ready_flag,
   input  wire logic        op_done,
   input  wire logic [12:0] spectrum_length,
   input  wire logic [7:0]  flashed_gain,
   input  wire logic [7:0]  computed_gain_result,
   output logic             op_start,
   output logic [7:0]       op_code,
   output logic [7:0]       gain_value,
   output logic [1:0]       gain_source_select,
   output logic [2:0]       apodization_window_select,
   output logic             absorbance_mode,
   output logic [23:0]      scan_duration_ms,
   output logic [12:0]      effective_points
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and serial clock edges

   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic       sclk_prev_q;
   logic       wake_prev_q;
   logic       csb_s;
   logic       sclk_s;
   logic       mosi_s;
   logic       wake_s;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       wake_rise;

   // Two flops on every pin; only the second stage feeds logic
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 4'h1;
         sync2_q <= 4'h1;
      end else begin
         sync1_q <= {wake_input, spi_mosi, spi_clk, spi_csb};
         sync2_q <= sync1_q;
      end
   end

   assign csb_s  = sync2_q[0];
   assign sclk_s = sync2_q[1];
   assign mosi_s = sync2_q[2];
   assign wake_s = sync2_q[3];

   // Edge history taken from the second stage
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_prev_q <= 1'b0;
         wake_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         wake_prev_q <= wake_s;
      end
   end

   assign sclk_rise = !csb_s && sclk_s && !sclk_prev_q;
   assign sclk_fall = !csb_s && !sclk_s && sclk_prev_q;
   assign wake_rise = wake_s && !wake_prev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial frame: command byte, then data bytes at auto-incremented addresses

   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic [1:0] byte_idx_q;
   logic       rd_cmd_q;
   logic [6:0] addr_q;
   logic [7:0] tx_q;
   logic       byte_done;
   logic [7:0] rx_byte;
   logic       wr_en;
   logic [7:0] rd_data;

   assign byte_done = sclk_rise && (bit_cnt_q == 3'h7);
   assign rx_byte   = {shift_q, mosi_s};
   assign wr_en     = byte_done && (byte_idx_q != 2'h0) && !rd_cmd_q;

   // Bit and byte tracking; a raised chip select aborts any partial byte
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_q  <= 3'h0;
         shift_q    <= 7'h00;
         byte_idx_q <= 2'h0;
         rd_cmd_q   <= 1'b0;
         addr_q     <= 7'h00;
         tx_q       <= 8'h00;
      end else if (csb_s) begin
         bit_cnt_q  <= 3'h0;
         byte_idx_q <= 2'h0;
         tx_q       <= 8'h00;
      end else if (sclk_rise) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q   <= rx_byte[6:0];
         if (bit_cnt_q == 3'h7) begin
            if (byte_idx_q != 2'h3) begin
               byte_idx_q <= byte_idx_q + 2'h1;
            end
            if (byte_idx_q == 2'h0) begin
               rd_cmd_q <= rx_byte[7];
               addr_q   <= rx_byte[6:0];
            end else begin
               // Reads skip one dummy byte before data appears
               tx_q   <= rd_cmd_q ? rd_data : 8'h00;
               addr_q <= addr_q + 7'h01;
            end
         end
      end
   end

   // Output bit changes on the falling edge so the host samples it stable
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         spi_miso <= 1'b0;
      end else if (csb_s) begin
         spi_miso <= 1'b0;
      end else if (sclk_fall) begin
         spi_miso <= tx_q[3'h7 - bit_cnt_q];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   logic        interp_en_q;
   logic        wave_unit_q;
   logic [1:0]  gain_sel_q;
   logic [2:0]  apodization_window_select_q;
   logic        units_q;
   logic [7:0]  ext_gain_q;
   logic [23:0] scan_q;
   logic [12:0] points_q;
   logic [12:0] outsize_q;
   logic [7:0]  launch_q;

   // Byte writes; plain integer fields, none carry a fraction here R01
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         interp_en_q <= 1'b0;
         wave_unit_q <= 1'b0;
         gain_sel_q  <= RST_GAIN_SEL;
         apodization_window_select_q   <= RST_APODIZATION_WINDOW_SELECT;
         units_q     <= 1'b0;
         ext_gain_q  <= RST_EXT_GAIN;
         scan_q      <= RST_SCAN;
         points_q    <= RST_POINTS;
      end else if (wr_en) begin
         if (addr_q == ADDR_INTERP) begin
            interp_en_q <= rx_byte[POS_INTERP];
         end else if (addr_q == ADDR_CONFIG) begin
            wave_unit_q <= rx_byte[0];
            gain_sel_q  <= rx_byte[POS_GAIN +: 2];                // R02
            apodization_window_select_q   <= rx_byte[POS_WIN +: 3];                 // R03
            units_q     <= rx_byte[POS_UNITS];                    // R04
         end else if (addr_q == ADDR_EXT_GAIN) begin
            ext_gain_q <= rx_byte;
         end else if (addr_q == ADDR_SCAN_0) begin
            scan_q[7:0] <= rx_byte;                               // R05
         end else if (addr_q == ADDR_SCAN_1) begin
            scan_q[15:8] <= rx_byte;
         end else if (addr_q == ADDR_SCAN_2) begin
            scan_q[23:16] <= rx_byte;
         end else if (addr_q == ADDR_POINTS_0) begin
            points_q[7:0] <= rx_byte;
         end else if (addr_q == ADDR_POINTS_1) begin
            points_q[12:8] <= rx_byte[4:0];
         end
      end
   end

   // Read-only length follows the processing side every cycle R08
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         outsize_q <= 13'h0000;
      end else begin
         outsize_q <= spectrum_length;
      end
   end

   // Read mux; unmapped bytes and reserved bits read zero
   always_comb begin
      if (addr_q == ADDR_INTERP) begin
         rd_data = {interp_en_q, 7'h00};
      end else if (addr_q == ADDR_CONFIG) begin
         rd_data = {1'b0, units_q, apodization_window_select_q, gain_sel_q, wave_unit_q};
      end else if (addr_q == ADDR_EXT_GAIN) begin
         rd_data = ext_gain_q;
      end else if (addr_q == ADDR_SCAN_0) begin
         rd_data = scan_q[7:0];
      end else if (addr_q == ADDR_SCAN_1) begin
         rd_data = scan_q[15:8];
      end else if (addr_q == ADDR_SCAN_2) begin
         rd_data = scan_q[23:16];
      end else if (addr_q == ADDR_POINTS_0) begin
         rd_data = points_q[7:0];
      end else if (addr_q == ADDR_POINTS_1) begin
         rd_data = {3'h0, points_q[12:8]};
      end else if (addr_q == ADDR_OUTSIZE_0) begin
         rd_data = outsize_q[7:0];
      end else if (addr_q == ADDR_OUTSIZE_1) begin
         rd_data = {3'h0, outsize_q[12:8]};
      end else if (addr_q == ADDR_LAUNCH) begin
         rd_data = launch_q;
      end else begin
         rd_data = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Derived settings driven to the signal chain

   logic [12:0] rounded_pts;

   // Nearest allowed step; ties at every midpoint go upward R06
   always_comb begin
      if (points_q < MID_97) begin
         rounded_pts = PTS_65;
      end else if (points_q < MID_193) begin
         rounded_pts = PTS_129;
      end else if (points_q < MID_385) begin
         rounded_pts = PTS_257;
      end else if (points_q < MID_769) begin
         rounded_pts = PTS_513;
      end else if (points_q < MID_1536) begin
         rounded_pts = PTS_1024;
      end else if (points_q < MID_3072) begin
         rounded_pts = PTS_2048;
      end else begin
         rounded_pts = PTS_4096;
      end
   end

   op_state_t state_q;

   // Registered settings; gain picked by source, units gated by sample scan
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         effective_points          <= PTS_NATIVE;
         gain_value                <= 8'h00;
         gain_source_select        <= RST_GAIN_SEL;
         apodization_window_select <= RST_APODIZATION_WINDOW_SELECT;
         absorbance_mode           <= 1'b0;
         scan_duration_ms          <= RST_SCAN;
      end else begin
         effective_points <= interp_en_q ? rounded_pts : PTS_NATIVE;                // R07
         if (gain_sel_q == GAIN_EXTERNAL) begin
            gain_value <= ext_gain_q;                                              // R02
         end else if (gain_sel_q == GAIN_COMPUTED) begin
            gain_value <= computed_gain_result;                                    // R13
         end else begin
            gain_value <= flashed_gain;
         end
         gain_source_select        <= gain_sel_q;
         apodization_window_select <= apodization_window_select_q;                                   // R03
         absorbance_mode <= units_q && (state_q == ST_BUSY) && (op_code == OP_SAMPLE_SCAN); // R04
         scan_duration_ms          <= scan_q;                                       // R05
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operation launch

   logic       launch_wr;
   logic       code_defined;
   logic       prereq_ok;
   logic       launch_ok;
   logic       ref_bg_seen_q;
   logic       bg_scan_seen_q;
   logic [7:0] code;

   assign code      = rx_byte;
   assign launch_wr = wr_en && (addr_q == ADDR_LAUNCH);
   // Codes 1-8 and 11-18 only; gaps start nothing R20
   assign code_defined = ((code >= OP_CAPTURE) && (code <= OP_SPEC_READ)) ||
                         ((code >= OP_STORE_FIRST) && (code <= OP_SAVE_CONTEXT));
   // Ordered pairs refused until their first step ran R12 R18
   assign prereq_ok = !((code == OP_REF_FIX) && !ref_bg_seen_q) &&
                      !((code == OP_SAMPLE_SCAN) && !bg_scan_seen_q);
   // Launch taken only when ready, as the host is expected to check R21
   assign launch_ok = launch_wr && code_defined && prereq_ok && (state_q == ST_IDLE);

   assign command_ready_flag = (state_q == ST_IDLE);

   // Stored code reads back whatever the host wrote last R09
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         launch_q <= 8'h00;
      end else if (launch_wr) begin
         launch_q <= code;
      end
   end

   // Routine start: one pulse with the code; routines decode it R10 R11 R15 R16 R17 R19
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         op_start <= 1'b0;
         op_code  <= 8'h00;
      end else begin
         op_start <= launch_ok;
         if (launch_ok) begin
            op_code <= code;                                      // R09
         end
      end
   end

   // Prerequisite memory; factory revert leaves it alone since scans stay valid
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ref_bg_seen_q  <= 1'b0;
         bg_scan_seen_q <= 1'b0;
      end else if (launch_ok) begin
         if (code == OP_REF_BG) begin
            ref_bg_seen_q <= 1'b1;                                // R12
         end
         if (code == OP_BG_SCAN) begin
            bg_scan_seen_q <= 1'b1;                               // R18
         end
      end
   end

   // Idle, running a routine, or asleep until wake rises
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (launch_ok) begin
                  state_q <= (code == OP_SLEEP) ? ST_SLEEP : ST_BUSY;   // R14
               end
            end
            ST_BUSY: begin
               if (op_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_SLEEP: begin
               if (wake_rise) begin
                  state_q <= ST_IDLE;                             // R14
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_round_low;
      interp_en_q && (points_q < MID_97) |=> effective_points == PTS_65;
   endproperty
   a_round_low: assert property (p_round_low) else $error("low count not rounded to 65"); // R06

   property p_interp_off;
      !interp_en_q |=> effective_points == PTS_NATIVE;
   endproperty
   a_interp_off: assert property (p_interp_off) else $error("count applied without interpolation"); // R07

   property p_launch;
      launch_wr && (code == OP_CAPTURE) && command_ready_flag |=> op_start && (op_code == OP_CAPTURE) ##1 !op_start;
   endproperty
   a_launch: assert property (p_launch) else $error("capture code did not start"); // R10

   property p_undefined;
      launch_wr && ((code == 8'h09) || (code == 8'h0A) || (code > OP_SAVE_CONTEXT)) |=> !op_start;
   endproperty
   a_undefined: assert property (p_undefined) else $error("undefined code started a routine"); // R20

   property p_ref_order;
      launch_wr && (code == OP_REF_FIX) && !ref_bg_seen_q |=> !op_start && $stable(state_q);
   endproperty
   a_ref_order: assert property (p_ref_order) else $error("reference fix ran before background"); // R12

   property p_sample_order;
      launch_wr && (code == OP_SAMPLE_SCAN) && !bg_scan_seen_q |=> !op_start;
   endproperty
   a_sample_order: assert property (p_sample_order) else $error("sample scan ran before background"); // R18

   property p_sleep;
      op_start && (op_code == OP_SLEEP) |-> !command_ready_flag ##1 ($past(wake_rise) || !command_ready_flag);
   endproperty
   a_sleep: assert property (p_sleep) else $error("ready while asleep"); // R14

   property p_ext_gain;
      (gain_sel_q == GAIN_EXTERNAL) |=> gain_value == $past(ext_gain_q);
   endproperty
   a_ext_gain: assert property (p_ext_gain) else $error("external gain not selected"); // R02

   property p_units;
      absorbance_mode |-> (op_code == OP_SAMPLE_SCAN) && $past(units_q);
   endproperty
   a_units: assert property (p_units) else $error("absorbance outside sample scan"); // R04

endmodule

// >>> test/spi_host_model.sv
// Host side SPI master model driving the command register block.
// Assumes mode 0, MSB first, and sys_clk as the common bench clock.
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic sys_clk,
   input  wire logic miso,
   input  wire logic ready,
   output logic      csb,
   output logic      sclk,
   output logic      mosi
);
   ////////////////////////////////////////
   // Idle pins; the clock stands still outside frames
   initial begin
      csb  = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // Wait n cycles and land just after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One byte; four cycle half period clears the pin synchronizers
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         tick(4);
         sclk = 1'b1;
         rx[i] = miso;
         tick(4);
         sclk = 1'b0;
      end
   endtask
   // Close frame; data line flips so a stale bit is never trusted
   task automatic close();
      tick(8);
      csb = 1'b1;
      mosi = ~mosi;
      tick(4);
   endtask
   // Write n bytes low first, once the ready flag reads high or after 500 cycles
   task automatic wr(input logic [6:0] a, input logic [23:0] v, input int n);
      logic [7:0] r;
      for (int i = 0; i < 500 && ready !== 1'b1; i++) tick(1);
      csb = 1'b0;
      tick(2);
      xfer({1'b0, a}, r);
      for (int i = 0; i < n; i++) xfer(v[8*i +: 8], r);
      close();
   endtask
   // Read n bytes; one dummy byte precedes the data
   task automatic rd(input logic [6:0] a, input int n, output logic [23:0] v);
      logic [7:0] r;
      v = '0;
      csb = 1'b0;
      tick(2);
      xfer({1'b1, a}, r);
      xfer(8'h00, r);
      for (int i = 0; i < n; i++) begin
         xfer(8'h00, r);
         v[8*i +: 8] = r;
      end
      close();
   endtask
endmodule

// >>> test/spectral_module_command_regs_bench.sv
// Self-checking bench for the command register block.
// Assumes the host model above and routine handshakes driven here.
`timescale 1ns/1ps
module spectral_module_command_regs_bench;
   import spec_cmd_pkg::*;
   logic        sys_clk, rstn, spi_csb, spi_clk, spi_mosi, spi_miso, wake_input;
   logic        command_ready_flag, op_done, op_start, absorbance_mode;
   logic [12:0] spectrum_length, effective_points;
   logic [7:0]  flashed_gain, computed_gain_result, op_code, gain_value;
   logic [1:0]  gain_source_select;
   logic [2:0]  apodization_window_select;
   logic [23:0] scan_duration_ms, v;
   int          starts, failures, checks_done;
   logic [7:0]  codes [20] = '{8'h04, 8'h11, 8'h09, 8'h0A, 8'h03, 8'h04, 8'h10, 8'h11, 8'h01, 8'h02,
                               8'h05, 8'h06, 8'h07, 8'h08, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h12};
   logic [12:0] pin [8] = '{13'h0000, 13'h0060, 13'h0061, 13'h0180, 13'h02FF, 13'h0301, 13'h0600, 13'h0C00};
   logic [12:0] pout [8] = '{PTS_65, PTS_65, PTS_129, PTS_257, PTS_513, PTS_1024, PTS_2048, PTS_4096};
   logic [7:0]  gexp [3] = '{8'h11, 8'h22, 8'h5A};
   ////////////////////////////////////////
   spectral_module_command_regs uut (.sys_clk(sys_clk), .rstn(rstn), .spi_csb(spi_csb), .spi_clk(spi_clk),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .wake_input(wake_input), .command_ready_flag(command_ready_flag),
      .op_done(op_done), .spectrum_length(spectrum_length), .flashed_gain(flashed_gain),
      .computed_gain_result(computed_gain_result), .op_start(op_start), .op_code(op_code),
      .gain_value(gain_value), .gain_source_select(gain_source_select),
      .apodization_window_select(apodization_window_select), .absorbance_mode(absorbance_mode),
      .scan_duration_ms(scan_duration_ms), .effective_points(effective_points));
   spi_host_model host (.sys_clk(sys_clk), .miso(spi_miso), .ready(command_ready_flag), .csb(spi_csb),
      .sclk(spi_clk), .mosi(spi_mosi));
   // Clock and launch pulse counter
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (op_start === 1'b1) starts++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [6:0] a, input int n, input logic [23:0] exp);
      host.rd(a, n, v);
      check(v, exp);
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Launch one code; accepted ones are finished by done or wake
   task automatic launch(input logic [7:0] code, input logic ok);
      int s0;
      s0 = starts;
      host.wr(ADDR_LAUNCH, {16'h0000, code}, 1);
      check(starts - s0, ok);
      rdchk(ADDR_LAUNCH, 1, {16'h0000, code});
      if (ok) begin
         check(op_code, code);
         check(command_ready_flag, 1'b0);
         check(absorbance_mode, code == OP_SAMPLE_SCAN);
         if (code == OP_SLEEP) wake_input = 1'b1;
         else op_done = 1'b1;
         host.tick(1);
         wake_input = 1'b0;
         op_done = 1'b0;
         host.tick(8);
         check(command_ready_flag, 1'b1);
      end
   endtask
   ////////////////////////////////////////
   // Hung handshakes must not stall the run
   initial begin
      #2_000_000;
      failures++;
      conclude();
   end
   initial begin
      rstn = 1'b0;
      wake_input = 1'b0;
      op_done = 1'b0;
      spectrum_length = 13'h0ABC;
      flashed_gain = 8'h11;
      computed_gain_result = 8'h22;
      repeat (20) @(posedge sys_clk);
      #1 rstn = 1'b1;
      host.tick(4);
      check({gain_source_select, apodization_window_select, absorbance_mode}, 0);
      check(effective_points, PTS_NATIVE);
      rdchk(ADDR_CONFIG, 1, 0);
      host.wr(ADDR_EXT_GAIN, 24'h00_005A, 1);
      for (int g = 0; g < 3; g++) begin
         host.wr(ADDR_CONFIG, 24'(g << POS_GAIN), 1);
         check(gain_value, gexp[g]);
         check(gain_source_select, g);
         rdchk(ADDR_CONFIG, 1, 24'(g << POS_GAIN));
      end
      for (int w = 0; w < 5; w++) begin
         host.wr(ADDR_CONFIG, 24'(w << POS_WIN), 1);
         check(apodization_window_select, w);
      end
      host.wr(ADDR_SCAN_0, 24'h12_3456, 3);
      check(scan_duration_ms, 24'h12_3456);
      rdchk(ADDR_SCAN_0, 3, 24'h12_3456);
      host.wr(7'h13, 24'h00_00FF, 1);
      rdchk(7'h13, 1, 0);
      rdchk(ADDR_OUTSIZE_0, 2, 24'h00_0ABC);
      host.wr(ADDR_INTERP, 24'h00_0080, 1);
      for (int i = 0; i < 8; i++) begin
         host.wr(ADDR_POINTS_0, {11'h000, pin[i]}, 2);
         check(effective_points, pout[i]);
      end
      host.wr(ADDR_INTERP, 0, 1);
      check(effective_points, PTS_NATIVE);
      host.wr(ADDR_CONFIG, 24'(1 << POS_UNITS), 1);
      for (int i = 0; i < 20; i++) launch(codes[i], i > 3);
      conclude();
   end
endmodule
